//--- etfd_pkg.sv
package etfd_pkg;
    // ==========================================================
    // clock and timing
    localparam int CLK_MHZ = 200;
    localparam int FILT_MIN_NS = 1000;
    localparam int FILT_CYC = (FILT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int OVH_NS = 3100;
    localparam int OVH_CYC = (OVH_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_INT2_NS = 10000;
    localparam int MIN_INT2_CYC = (MIN_INT2_NS * CLK_MHZ + 999) / 1000;
    // ==========================================================
    // settings and reset values
    localparam logic [1:0] SNAP_OFF = 2'h0;
    localparam logic [1:0] SNAP_CONC = 2'h1;
    localparam logic [1:0] SNAP_PRE = 2'h2;
    localparam logic [1:0] SNAP_RST = 2'h1;
    localparam logic FILT_RST = 1'h0;
    localparam logic [2:0] DUMPS_MIN = 3'h1;
    localparam logic [2:0] DUMPS_MAX = 3'h7;
    localparam logic [2:0] DUMPS_RST = 3'h1;
    localparam int CNT_W = 24;
    localparam int ROWS_W = 12;
    // per-row dump cycles at 200 MHz clock, per rate and tap count
    localparam logic [7:0] ROW_CYC_80_4T = 8'h14;
    localparam logic [7:0] ROW_CYC_65_4T = 8'h19;
    localparam logic [7:0] ROW_CYC_80_2T = 8'h28;
    localparam logic [7:0] ROW_CYC_65_2T = 8'h32;
    localparam logic [7:0] CSN_USER_OFS = 8'h8;
    localparam logic [3:0] CSN_UNITY = 4'h6;
    localparam logic [3:0] CSN_TESTPAT = 4'h7;
    localparam logic [7:0] READOUT_FACTOR = 8'h2;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DUMP = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_EXPO = 5'b01000,
        ST_READ = 5'b10000
    } etfd_state_e;
endpackage

//--- etfd_sync_filter.sv
`timescale 1ns/1ps
`default_nettype none
module etfd_sync_filter (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // synchronised reset
    input wire logic ce, // clock enable
    input wire logic filt_en, // filter enable
    input wire logic pin_in, // raw sync pin
    output logic level_out // conditioned level
);
    // ==========================================================
    // three-stage capture; only stages 2 and 3 are compared
    logic s1_ff, s2_ff, s3_ff;
    logic [15:0] stab_ff;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
        end else if (ce) begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end
    // ==========================================================
    // stable-level qualification
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stab_ff <= 16'h0;
            level_out <= 1'b0;
        end else if (ce) begin
            if (s2_ff != s3_ff) begin
                stab_ff <= 16'h0;
            end else if (!filt_en) begin
                level_out <= s3_ff;
            end else if (s3_ff == level_out) begin
                stab_ff <= 16'h0;
            end else if (stab_ff >= 16'(etfd_pkg::FILT_CYC - 1)) begin
                level_out <= s3_ff;
                stab_ff <= 16'h0;
            end else begin
                stab_ff <= stab_ff + 16'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- etfd_ctrl.sv
// What this block does
// - with filtering on, pulses under one microsecond are ignored
// - filter setting: zero turns it off, one turns it on
// - filter is off after reset
// - snapshot selector takes 0 (no dumps), 1 or 2
// - variant 1 clears the sensor concurrently with integration
// - variant 1 integration is sync high time plus dump count times dump time plus 3.1 us
// - variant 1 integration never shorter than dump time plus 3.1 us
// - variant 1 is the reset selection
// - variant 2 waits the dump time between integration and exposure
// - variant 2 supports integration down to 10 us
// - variant 2 never lets exposure overlap readout
// - variant 1 starts the dump at sync falling edge
// - variant 2 starts the dump at sync rising edge
// - dump time depends on rows, output rate and tap count
// - exact dump time is reported on an output
// - dump count 1 to 7 dumps per sequence
// - dump count ignored in snapshot mode 0
// - maximum frame rate limit falls as dump count rises, reported out
// - sixteen coefficient sets: eight factory, eight user
// - sets matched to snapshot mode: mode 1 to 0/3, mode 0 to 1/4, mode 2 to 2/5 families
// - set 6 is no correction, set 7 from test patterns
// - sets 8 to 15 user writable, mirroring factory set minus eight
`timescale 1ns/1ps
`default_nettype none
module etfd_ctrl (
    input wire logic clk_sys, // 200 MHz clock
    input wire logic rstn, // async reset, active low
    input wire logic ce, // clock enable
    input wire logic external_exposure_sync, // sync pin from grabber
    input wire logic filt_en_cfg, // sync filter setting
    input wire logic [1:0] snap_mode_cfg, // snapshot selector
    input wire logic [2:0] dump_cnt_cfg, // dumps per sequence
    input wire logic cfg_wr, // one-cycle strobe loading settings
    input wire logic [etfd_pkg::ROWS_W-1:0] rows_active, // active rows
    input wire logic rate_65, // 1: 65 MHz output, 0: 80 MHz
    input wire logic four_tap, // 1: four taps, 0: two taps
    input wire logic [etfd_pkg::CNT_W-1:0] readout_cyc, // readout length
    input wire logic [1:0] csn_bank, // 0 or 1: family member
    input wire logic csn_user, // select user copy
    input wire logic csn_special, // pick unity or test set
    input wire logic csn_test, // with special: test-pattern set
    output logic filt_en, // active filter setting
    output logic [1:0] snap_mode, // active snapshot mode
    output logic [2:0] dump_cnt, // active dump count
    output logic dump_active, // fast frame dump in progress
    output logic integrating, // sensor integrating
    output logic exposing, // exposure window open
    output logic reading, // frame readout in progress
    output logic [etfd_pkg::CNT_W-1:0] dump_time_cyc, // dump duration y
    output logic [etfd_pkg::CNT_W-1:0] min_frame_cyc, // minimum frame period
    output logic [3:0] coef_set, // selected coefficient set
    output logic coef_set_user_wr, // selected set is writable
    output logic cfg_err // last setting rejected
);
    localparam int CNT_W = etfd_pkg::CNT_W;
    // ==========================================================
    // reset release
    logic r1_ff, r2_ff;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            r1_ff <= 1'b0;
            r2_ff <= 1'b0;
        end else begin
            r1_ff <= 1'b1;
            r2_ff <= r1_ff;
        end
    end
    wire logic rst_n = r2_ff;
    // ==========================================================
    // settings
    wire logic snap_ok = (snap_mode_cfg != 2'h3);
    wire logic cnt_ok = (dump_cnt_cfg >= etfd_pkg::DUMPS_MIN)
        && (dump_cnt_cfg <= etfd_pkg::DUMPS_MAX);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            filt_en <= etfd_pkg::FILT_RST;
        end else if (ce && cfg_wr) begin
            filt_en <= filt_en_cfg;
        end
    end
    // a refused selector keeps the running mode rather than guessing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snap_mode <= etfd_pkg::SNAP_RST;
        end else if (ce && cfg_wr && snap_ok) begin
            snap_mode <= snap_mode_cfg;
        end
    end
    // count is held in mode 0 too; it acts when a sequence starts and, outside mode 0, in the frame-period limit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dump_cnt <= etfd_pkg::DUMPS_RST;
        end else if (ce && cfg_wr && cnt_ok) begin
            dump_cnt <= dump_cnt_cfg;
        end
    end
    // flags the last write only; a good write clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_err <= 1'b0;
        end else if (ce && cfg_wr) begin
            cfg_err <= !(snap_ok && cnt_ok);
        end
    end
    // ==========================================================
    // conditioned sync and edges
    logic sync_lvl, sync_d_ff;
    etfd_sync_filter u_filt (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .filt_en(filt_en),
        .pin_in(external_exposure_sync),
        .level_out(sync_lvl)
    );
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync_d_ff <= 1'b0;
        end else if (ce) begin
            sync_d_ff <= sync_lvl;
        end
    end
    wire logic sync_rise = sync_lvl && !sync_d_ff;
    wire logic sync_fall = !sync_lvl && sync_d_ff;
    // ==========================================================
    // dump duration and frame-rate limit
    logic [7:0] row_cyc;
    always_comb begin
        case ({four_tap, rate_65})
            2'b10: row_cyc = etfd_pkg::ROW_CYC_80_4T;
            2'b11: row_cyc = etfd_pkg::ROW_CYC_65_4T;
            2'b00: row_cyc = etfd_pkg::ROW_CYC_80_2T;
            default: row_cyc = etfd_pkg::ROW_CYC_65_2T;
        endcase
    end
    // registered so the reported figure is stable glitch-free
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dump_time_cyc <= '0;
            min_frame_cyc <= '0;
        end else if (ce) begin
            dump_time_cyc <= CNT_W'(rows_active)
                * CNT_W'(row_cyc);
            if (snap_mode == etfd_pkg::SNAP_OFF) begin
                min_frame_cyc <= readout_cyc;
            end else begin
                min_frame_cyc <= CNT_W'(readout_cyc
                    + dump_cnt * dump_time_cyc
                    + etfd_pkg::OVH_CYC);
            end
        end
    end
    // ==========================================================
    // sequencer
    etfd_pkg::etfd_state_e st_ff, nxt_st;
    logic [CNT_W-1:0] tmr_ff, nxt_tmr;
    logic [2:0] left_ff, nxt_left;
    logic [1:0] run_mode_ff;
    wire logic tmr_done = (tmr_ff == '0);
    always_comb begin
        nxt_st = st_ff;
        nxt_tmr = tmr_done ? tmr_ff : tmr_ff - 1'b1;
        nxt_left = left_ff;
        case (st_ff)
            etfd_pkg::ST_IDLE: begin
                // mode 0 ignores dump count and never dumps
                if (snap_mode == etfd_pkg::SNAP_CONC && sync_fall) begin
                    nxt_st = etfd_pkg::ST_DUMP;
                    nxt_tmr = dump_time_cyc;
                    nxt_left = dump_cnt;
                end else if (snap_mode == etfd_pkg::SNAP_PRE
                    && sync_rise) begin
                    nxt_st = etfd_pkg::ST_DUMP;
                    nxt_tmr = dump_time_cyc;
                    nxt_left = dump_cnt;
                end else if (snap_mode == etfd_pkg::SNAP_OFF
                    && sync_rise) begin
                    nxt_st = etfd_pkg::ST_EXPO;
                    nxt_tmr = '0;
                end
            end
            etfd_pkg::ST_DUMP: begin
                if (tmr_done) begin
                    if (left_ff > 3'h1) begin
                        nxt_left = left_ff - 3'h1;
                        nxt_tmr = dump_time_cyc;
                    end else if (run_mode_ff == etfd_pkg::SNAP_CONC) begin
                        nxt_st = etfd_pkg::ST_WAIT;
                        nxt_tmr = CNT_W'(etfd_pkg::OVH_CYC);
                    end else begin
                        nxt_st = etfd_pkg::ST_EXPO;
                        nxt_tmr = CNT_W'(etfd_pkg::MIN_INT2_CYC);
                    end
                end
            end
            etfd_pkg::ST_WAIT: begin
                if (tmr_done) begin
                    nxt_st = etfd_pkg::ST_READ;
                    nxt_tmr = readout_cyc;
                end
            end
            etfd_pkg::ST_EXPO: begin
                // sync low ends exposure once the minimum has passed
                if (tmr_done && !sync_lvl) begin
                    nxt_st = etfd_pkg::ST_READ;
                    nxt_tmr = readout_cyc;
                end
            end
            etfd_pkg::ST_READ: begin
                if (tmr_done) begin
                    nxt_st = etfd_pkg::ST_IDLE;
                end
            end
            default: begin
                nxt_st = etfd_pkg::ST_IDLE;
                nxt_tmr = '0;
            end
        endcase
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= etfd_pkg::ST_IDLE;
            tmr_ff <= '0;
            left_ff <= 3'h0;
            run_mode_ff <= etfd_pkg::SNAP_OFF;
        end else if (ce) begin
            st_ff <= nxt_st;
            tmr_ff <= nxt_tmr;
            left_ff <= nxt_left;
            if (st_ff == etfd_pkg::ST_IDLE) begin
                run_mode_ff <= snap_mode;
            end
        end
    end
    // ==========================================================
    // phase outputs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dump_active <= 1'b0;
        end else if (ce) begin
            dump_active <= (nxt_st == etfd_pkg::ST_DUMP);
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reading <= 1'b0;
        end else if (ce) begin
            reading <= (nxt_st == etfd_pkg::ST_READ);
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            exposing <= 1'b0;
        end else if (ce) begin
            exposing <= (nxt_st == etfd_pkg::ST_EXPO);
        end
    end
    // variant 1 integration spans sync high, dumps and overhead; the pin
    // is followed only while no sequence starts, so the hand-over into
    // the dump never drops integration for a cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            integrating <= 1'b0;
        end else if (ce) begin
            if (snap_mode == etfd_pkg::SNAP_CONC
                && nxt_st == etfd_pkg::ST_IDLE) begin
                integrating <= sync_lvl;
            end else begin
                integrating <= (nxt_st == etfd_pkg::ST_DUMP)
                    || (nxt_st == etfd_pkg::ST_WAIT)
                    || (nxt_st == etfd_pkg::ST_EXPO);
            end
        end
    end
    // ==========================================================
    // coefficient set selection
    logic [3:0] fam;
    always_comb begin
        case (snap_mode)
            etfd_pkg::SNAP_CONC: fam = 4'h0;
            etfd_pkg::SNAP_OFF: fam = 4'h1;
            default: fam = 4'h2;
        endcase
        if (csn_special) begin
            fam = csn_test ? etfd_pkg::CSN_TESTPAT
                : etfd_pkg::CSN_UNITY;
        end else if (csn_bank[0]) begin
            fam = fam + 4'h3;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            coef_set <= 4'h0;
            coef_set_user_wr <= 1'b0;
        end else if (ce) begin
            coef_set <= csn_user ? fam + etfd_pkg::CSN_USER_OFS[3:0]
                : fam;
            coef_set_user_wr <= csn_user;
        end
    end
endmodule
`default_nettype wire

//--- etfd_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module etfd_ctrl_assertions (
    input wire logic clk_sys, // clock
    input wire logic rstn, // async reset
    input wire logic ce, // clock enable
    input wire logic cfg_wr, // settings strobe
    input wire logic external_exposure_sync, // raw pin
    input wire logic filt_en_cfg, // filter request
    input wire logic [1:0] snap_mode_cfg, // selector request
    input wire logic [1:0] snap_mode, // active selector
    input wire logic [2:0] dump_cnt_cfg, // count request
    input wire logic [2:0] dump_cnt, // active count
    input wire logic filt_en, // active filter
    input wire logic cfg_err, // setting rejected
    input wire logic coef_set_user_wr, // writable set
    input wire logic dump_active, // dump phase
    input wire logic integrating, // integration phase
    input wire logic exposing, // exposure phase
    input wire logic reading, // readout phase
    input wire logic [3:0] coef_set, // coefficient set
    input wire logic [etfd_pkg::CNT_W-1:0] dump_time_cyc // dump length
);
    // ==========================================
    // helpers
    logic [15:0] hi_cnt_ff;
    logic [etfd_pkg::CNT_W-1:0] int_cnt_ff;
    logic busy;
    assign busy = dump_active | integrating | exposing | reading;
    // counts the raw pin, so the filter is judged before its own synchroniser
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) hi_cnt_ff <= 16'h0;
        else if (!external_exposure_sync) hi_cnt_ff <= 16'h0;
        else if (hi_cnt_ff != 16'hffff) hi_cnt_ff <= hi_cnt_ff + 16'h1;
    end
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) int_cnt_ff <= '0;
        else if (integrating) int_cnt_ff <= int_cnt_ff + 1'b1;
        else int_cnt_ff <= '0;
    end
    // ==========================================
    // properties
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    cfg_load_a: assert property (
        ce && cfg_wr && snap_mode_cfg inside {2'h1, 2'h2} && dump_cnt_cfg
        != 3'h0 |=> snap_mode == $past(snap_mode_cfg) && dump_cnt ==
        $past(dump_cnt_cfg) && filt_en == $past(filt_en_cfg))
        else $error("setting not loaded");
    cfg_refuse_a: assert property (
        ce && cfg_wr && snap_mode_cfg == 2'h3
        |=> cfg_err && $stable(snap_mode))
        else $error("bad selector accepted");
    field_range_a: assert property (
        snap_mode != 2'h3 && dump_cnt != 3'h0)
        else $error("setting out of range");
    no_overlap_a: assert property (!(exposing && reading))
        else $error("exposure overlaps readout");
    dump_first_a: assert property (exposing |-> !dump_active)
        else $error("exposure during dump");
    user_wr_a: assert property (coef_set_user_wr == coef_set[3])
        else $error("writable flag wrong");
    filter_min_a: assert property (
        filt_en && $rose(busy) |-> hi_cnt_ff >= 16'(etfd_pkg::FILT_CYC))
        else $error("short pulse passed filter");
    fall_dump_a: assert property (
        snap_mode == 2'h1 && !filt_en && integrating &&
        $fell(external_exposure_sync) |-> ##[1:8] dump_active)
        else $error("no dump after falling edge");
    rise_dump_a: assert property (
        snap_mode == 2'h2 && !filt_en && !busy &&
        $rose(external_exposure_sync) |-> ##[1:8] dump_active)
        else $error("no dump after rising edge");
    int_min_a: assert property (
        snap_mode == 2'h1 && $fell(integrating) |->
        int_cnt_ff >= dump_time_cyc + etfd_pkg::OVH_CYC)
        else $error("integration too short");
    cover property (snap_mode == 2'h1 && $rose(dump_active));
    cover property (snap_mode == 2'h2 && $rose(exposing));
    cover property (filt_en && $rose(exposing));
    cover property (cfg_err);
endmodule
bind etfd_ctrl etfd_ctrl_assertions etfd_ctrl_assertions_inst (
    .clk_sys, .rstn, .ce, .cfg_wr, .external_exposure_sync, .filt_en_cfg,
    .snap_mode_cfg, .snap_mode, .dump_cnt_cfg, .dump_cnt, .filt_en,
    .cfg_err, .coef_set_user_wr, .dump_active, .integrating, .exposing,
    .reading, .coef_set, .dump_time_cyc);
`default_nettype wire

//--- etfd_grabber_model.sv
`timescale 1ns/1ps
`default_nettype none
module etfd_grabber_model (
    input wire logic clk_sys, // shared clock
    input wire logic start, // launch one sync pulse
    input wire logic [15:0] high_cyc, // pulse high time in cycles
    output logic sync // exposure sync pin
);
    int left;
    initial left = 0;
    // pin moves just after the rising edge, as a real grabber output would
    always @(posedge clk_sys) begin
        if (left > 1) left <= left - 1;
        else if (start) left <= int'(high_cyc);
        else left <= 0;
    end
    assign sync = (left != 0);
endmodule
`default_nettype wire

//--- etfd_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module etfd_ctrl_bench;
    logic clk_sys, rstn, ce, cfg_wr, filt_en_cfg, rate_65, four_tap, start;
    logic csn_user, csn_special, csn_test, external_exposure_sync, cfg_err;
    logic filt_en, dump_active, integrating, exposing, reading;
    logic coef_set_user_wr;
    logic [1:0] snap_mode_cfg, csn_bank, snap_mode, es;
    logic [2:0] dump_cnt_cfg, dump_cnt, ed;
    logic [3:0] coef_set;
    logic [15:0] high_cyc;
    logic [etfd_pkg::ROWS_W-1:0] rows_active;
    logic [etfd_pkg::CNT_W-1:0] readout_cyc, dump_time_cyc, min_frame_cyc;
    int fails, checked, dcnt, icnt, ecnt, rcnt;
    etfd_ctrl etfd_ctrl_inst (.clk_sys, .rstn, .ce, .external_exposure_sync,
        .filt_en_cfg, .snap_mode_cfg, .dump_cnt_cfg, .cfg_wr, .rows_active,
        .rate_65, .four_tap, .readout_cyc, .csn_bank, .csn_user, .csn_special,
        .csn_test, .filt_en, .snap_mode, .dump_cnt, .dump_active, .integrating,
        .exposing, .reading, .dump_time_cyc, .min_frame_cyc, .coef_set,
        .coef_set_user_wr, .cfg_err);
    etfd_grabber_model etfd_grabber_model_inst (.clk_sys, .start, .high_cyc,
        .sync(external_exposure_sync));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        dcnt <= dcnt + int'(dump_active);
        icnt <= icnt + int'(integrating);
        ecnt <= ecnt + int'(exposing);
        rcnt <= rcnt + int'(reading);
    end
    // ==========================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic logic [7:0] row_cyc(logic r65, logic t4);
        if (t4) return r65 ? etfd_pkg::ROW_CYC_65_4T : etfd_pkg::ROW_CYC_80_4T;
        return r65 ? etfd_pkg::ROW_CYC_65_2T : etfd_pkg::ROW_CYC_80_2T;
    endfunction
    function automatic logic [3:0] exp_coef(logic [1:0] m, logic b, u, s, t);
        logic [3:0] c;
        c = (m == 2'h1) ? 4'h0 : (m == 2'h0) ? 4'h1 : 4'h2;
        if (b) c = c + 4'h3;
        if (s) c = t ? etfd_pkg::CSN_TESTPAT : etfd_pkg::CSN_UNITY;
        return u ? c + 4'h8 : c;
    endfunction
    task automatic cfg(input logic f, input logic [1:0] s,
        input logic [2:0] d);
        @(negedge clk_sys);
        filt_en_cfg = f;
        snap_mode_cfg = s;
        dump_cnt_cfg = d;
        cfg_wr = 1'b1;
        @(negedge clk_sys);
        cfg_wr = 1'b0;
        @(negedge clk_sys);
        if (s != 2'h3) es = s;
        if (d != 3'h0) ed = d;
        chk(snap_mode, es);
        if (s inside {2'h1, 2'h2}) chk(dump_cnt, ed);
        chk(filt_en, f);
        chk(cfg_err, s == 2'h3 || d == 3'h0);
    endtask
    // waits out the longest idle gap inside a sequence before calling it over
    task automatic seq(input int x);
        int q;
        @(negedge clk_sys);
        dcnt = 0;
        icnt = 0;
        ecnt = 0;
        rcnt = 0;
        high_cyc = 16'(x);
        start = 1'b1;
        @(negedge clk_sys);
        start = 1'b0;
        q = 0;
        for (int i = 0; i < 40000 && q < 700; i++) begin
            @(negedge clk_sys);
            q = (external_exposure_sync || dump_active || integrating ||
                exposing || reading) ? 0 : q + 1;
        end
    endtask
    // ==========================================
    // tests
    initial begin
        int x, y;
        void'($urandom(32'h5da237f2));
        {rstn, cfg_wr, filt_en_cfg, rate_65, four_tap, start} = '0;
        {csn_user, csn_special, csn_test, csn_bank} = '0;
        {snap_mode_cfg, dump_cnt_cfg, high_cyc} = '0;
        ce = 1'b1;
        rows_active = 12'h4;
        readout_cyc = 24'h80;
        es = etfd_pkg::SNAP_CONC;
        ed = 3'h1;
        repeat (20) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(filt_en, 1'b0);
        chk(snap_mode, etfd_pkg::SNAP_CONC);
        chk(dump_cnt, etfd_pkg::DUMPS_RST);
        for (int i = 0; i < 16; i++) begin
            if (i < 8) cfg(1'b0, 2'(i), 3'(i));
            else cfg(1'($urandom), 2'($urandom), 3'(1 + $urandom % 7));
        end
        $display("test settings done");
        for (int k = 0; k < 4; k++) begin
            @(negedge clk_sys);
            rate_65 = k[0];
            four_tap = k[1];
            rows_active = 12'(1 + $urandom % 8);
            readout_cyc = 24'(64 + $urandom % 256);
            y = int'(rows_active) * int'(row_cyc(rate_65, four_tap));
            cfg(1'b0, 2'(1 + k % 2), 3'(1 + $urandom % 7));
            chk(dump_time_cyc, y);
            chk(min_frame_cyc, readout_cyc + ed * y
                + etfd_pkg::OVH_CYC);
            x = 50 + $urandom % 250;
            cfg(1'b0, 2'h1, ed);
            seq(x);
            chk(dcnt, ed * (y + 1));
            chk(icnt, x + dcnt + etfd_pkg::OVH_CYC + 1);
            cfg(1'b0, 2'h2, ed);
            seq(50);
            chk(dcnt, ed * (y + 1));
            x = etfd_pkg::MIN_INT2_CYC;
            chk(ecnt >= x && ecnt <= x + 2, 1'b1);
            cfg(1'b0, 2'h0, ed);
            chk(min_frame_cyc, readout_cyc);
            seq(100);
            chk(dcnt, 0);
            chk(ecnt > 0 && rcnt > 0, 1'b1);
            $display("test timing %0d done", k);
        end
        // clock enable low must swallow a settings strobe whole
        @(negedge clk_sys);
        ce = 1'b0;
        {filt_en_cfg, snap_mode_cfg, cfg_wr} = {1'b1, 2'h2, 1'b1};
        dump_cnt_cfg = 3'(ed % 7 + 1);
        repeat (2) @(negedge clk_sys);
        {ce, cfg_wr} = 2'b10;
        @(negedge clk_sys);
        chk({filt_en, snap_mode, dump_cnt}, {1'b0, 2'h0, ed});
        cfg(1'b1, 2'h0, 3'h1);
        seq(150);
        chk(dcnt + icnt + ecnt + rcnt, 0);
        seq(etfd_pkg::FILT_CYC + 60);
        chk(ecnt > 0, 1'b1);
        cfg(1'b0, 2'h0, 3'h1);
        seq(20);
        chk(ecnt > 0, 1'b1);
        $display("test filter done");
        for (int j = 0; j < 12; j++) begin
            if (j % 4 == 0) cfg(1'b0, 2'(j / 4), 3'h1);
            @(negedge clk_sys);
            csn_bank = 2'($urandom);
            csn_user = 1'($urandom);
            csn_special = (j % 4 < 2);
            csn_test = j[0];
            repeat (3) @(negedge clk_sys);
            chk(coef_set, exp_coef(snap_mode_cfg, csn_bank[0], csn_user,
                csn_special, csn_test));
            chk(coef_set_user_wr, csn_user);
        end
        $display("test coefficients done");
        test_done();
    end
    initial begin
        repeat (95000) @(posedge clk_sys);
        fails++;
        test_done();
    end
endmodule
`default_nettype wire
